// >>> bench/power_supervisor_flags_switchover_bench.sv
/* Testbench of the power supervisor.
   Assumes the register port contract of the design. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module power_supervisor_flags_switchover_bench
  import psf_pkg::*;
  ;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, bwr = 0, bval = 0, fail = 0, dcl = 0, deep = 0, rxe = 0, pin = 1;
  logic [7:0] addr = 0, wd = 0, badr = 0, rv, en, e, rdata;
  logic [5:0] ev = 0;
  logic [1:0] rxfn, code;
  logic       rail, refon, irq0, rxen, pirq, mlow, mgood, sw, wreq;
  int         failures = 0, samples_checked = 0, seed = 32'he1c7d6f2;
  psf_supply_model psf_supply_model_i (.sys_clk_in(clk), .fail_in(fail), .main_low_out(mlow), .main_good_out(mgood));
  psf_supervisor psf_supervisor_i (.sys_clk_in(clk), .arst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wdata_in(wd),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .bit_wr_in(bwr), .bit_addr_in(badr), .bit_val_in(bval), .main_low_in(mlow),
    .main_good_in(mgood), .dc_input_low_in(dcl), .dc_delta_in(ev[0]), .dc_ready_in(ev[1]), .battery_below_in(ev[2]),
    .battery_ready_in(ev[3]), .sag_in(ev[4]), .lock_lost_in(ev[5]), .deepest_battery_mode_in(deep), .rx_edge_in(rxe),
    .ext_irq0_pin_in(pin), .sfr_rdata_out(rdata), .rail_to_battery_out(rail), .reference_keep_on_out(refon),
    .external_irq_zero_out(irq0), .rx_pin_function_out(rxfn), .rx_wake_enable_out(rxen), .wake_request_out(wreq),
    .power_irq_out(pirq));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [7:0] fexp(input int i, input logic [7:0] m);
    int b;
    b = (i < 2) ? 3 : (i < 4) ? 2 : 5;
    return (8'h01 << b) | (m[b] ? 8'h40 : 8'h00);
  endfunction : fexp
  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    ev = 6'h00;
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    rv = rdata;
  endtask : rdr
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wrr
  task automatic bw(input logic [7:0] a, input logic v);
    @(negedge clk);
    bwr = 1'b1;
    badr = a;
    bval = v;
    @(negedge clk);
    bwr = 1'b0;
  endtask : bw
  task give_verdict;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    #50000;
    failures++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rdr(PSF_ADDR_FLAGS);
    `CHK(rv, PSF_FLAGS_RST)
    rdr(PSF_ADDR_PERIPHERAL_CONFIG);
    `CHK(rv, 8'h60)
    rdr(PSF_ADDR_SWCFG);
    `CHK(rv, PSF_SWCFG_RST)
    `CHK(irq0, 1'b0)
    wrr(PSF_ADDR_WAKECFG, 8'h01);
    repeat (2) @(negedge clk);
    `CHK(irq0, 1'b1)
    for (int i = 0; i < 5; i++)
    begin
      en = 8'($random(seed)) & 8'haf;
      e = fexp(i, en);
      wrr(PSF_ADDR_IRQEN, en);
      @(negedge clk);
      ev[i] = 1'b1;
      rdr(PSF_ADDR_FLAGS);
      `CHK(rv, e)
      `CHK(pirq, e[6])
      wrr(PSF_ADDR_FLAGS, 8'h00);
      rdr(PSF_ADDR_FLAGS);
      `CHK(rv, 8'h00)
    end
    wrr(PSF_ADDR_IRQEN, 8'h00);
    @(negedge clk);
    ev[4] = 1'b1;
    wr = 1'b1;
    addr = PSF_ADDR_FLAGS;
    wd = 8'h00;
    @(negedge clk);
    wr = 1'b0;
    ev = 6'h00;
    rdr(PSF_ADDR_FLAGS);
    `CHK(rv, 8'h20)
    bw(8'hfd, 1'b0);
    rdr(PSF_ADDR_FLAGS);
    `CHK(rv, 8'h00)
    @(negedge clk);
    ev[5] = 1'b1;
    rdr(PSF_ADDR_PERIPHERAL_CONFIG);
    `CHK(rv & 8'h10, 8'h10)
    bw(PSF_ADDR_CONVST, 1'b1);
    rdr(PSF_ADDR_PERIPHERAL_CONFIG);
    `CHK(rv & 8'h10, 8'h00)
    for (int s = 0; s < 8; s++)
    begin
      wrr(PSF_ADDR_SWCFG, 8'(s >> 1));
      wrr(PSF_ADDR_FLAGS, 8'h00);
      fail = !s[0];
      dcl = s[0];
      sw = s[2] ? 1'b0 : (fail || (s[1] && dcl));
      repeat (4) @(negedge clk);
      `CHK(rail, sw)
      rdr(PSF_ADDR_PERIPHERAL_CONFIG);
      `CHK(rv[6], !sw)
      `CHK(rv[5], !fail)
      rdr(PSF_ADDR_FLAGS);
      `CHK(rv & 8'h03, {6'h00, sw, dcl})
      fail = 1'b0;
      dcl = 1'b0;
      repeat (4) @(negedge clk);
      rdr(PSF_ADDR_FLAGS);
      `CHK(rv[7], sw)
    end
    deep = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      code = (k == 2) ? PSF_RX_WAKE : 2'(k);
      wrr(PSF_ADDR_PERIPHERAL_CONFIG, {6'h02, code});
      repeat (2) @(negedge clk);
      `CHK(rxfn, code)
      `CHK(rxen, code == PSF_RX_WAKE)
      `CHK(refon, 1'b1)
      rxe = 1'b1;
      @(negedge clk);
      `CHK(wreq, code == PSF_RX_WAKE)
      rxe = 1'b0;
      rdr(PSF_ADDR_PERIPHERAL_CONFIG);
      `CHK(rv[7], code == PSF_RX_WAKE)
    end
    pin = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(irq0, 1'b0)
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rdr(PSF_ADDR_PERIPHERAL_CONFIG);
    `CHK(rv, 8'h60)
    `CHK(rxfn, PSF_RXFN_RST)
    rdr(PSF_ADDR_WAKECFG);
    `CHK(rv, 8'h00)
    give_verdict();
  end
endmodule : power_supervisor_flags_switchover_bench

// >>> bench/psf_supervisor_asserts.sv
/* Port checker for the power supervisor.
   Assumes it is bound to psf_supervisor. */
`timescale 1ns/1ps
module psf_supervisor_asserts
  import psf_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       arst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_rd_in,
  input wire logic       ext_irq0_pin_in,
  input wire logic       main_low_in,
  input wire logic       dc_input_low_in,
  input wire logic       main_good_in,
  input wire logic       sag_in,
  input wire logic       lock_lost_in,
  input wire logic       deepest_battery_mode_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       rail_to_battery_out,
  input wire logic       reference_keep_on_out,
  input wire logic       external_irq_zero_out,
  input wire logic [1:0] rx_pin_function_out,
  input wire logic       rx_wake_enable_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_irq0; !ext_irq0_pin_in |=> !external_irq_zero_out; endproperty
  property p_rail;
    $rose(rail_to_battery_out) |-> $past(main_low_in || dc_input_low_in) || $past(main_low_in || dc_input_low_in, 2);
  endproperty
  property p_dip; sfr_rd_in && sfr_addr_in == PSF_ADDR_FLAGS && $past(sag_in) |=> sfr_rdata_out[PSF_F_DIP]; endproperty
  property p_lock;
    sfr_rd_in && sfr_addr_in == PSF_ADDR_PERIPHERAL_CONFIG && $past(lock_lost_in) |=> sfr_rdata_out[PSF_P_LOCK];
  endproperty
  property p_source;
    sfr_rd_in && sfr_addr_in == PSF_ADDR_PERIPHERAL_CONFIG && rail_to_battery_out && $past(rail_to_battery_out)
      |=> !sfr_rdata_out[PSF_P_SOURCE];
  endproperty
  property p_good;
    sfr_rd_in && sfr_addr_in == PSF_ADDR_PERIPHERAL_CONFIG && main_good_in && $past(main_good_in) |=> sfr_rdata_out[PSF_P_GOOD];
  endproperty
  property p_refon; reference_keep_on_out |-> $past(deepest_battery_mode_in); endproperty
  property p_rxen; rx_wake_enable_out == ($past(rx_pin_function_out) == PSF_RX_WAKE); endproperty
  a_irq0: assert property (p_irq0) else $error("irq0 output without pin");
  a_rail: assert property (p_rail) else $error("rail moved without cause");
  a_dip: assert property (p_dip) else $error("sag flag missing");
  a_lock: assert property (p_lock) else $error("lock fault missing");
  a_source: assert property (p_source) else $error("source bit wrong");
  a_good: assert property (p_good) else $error("supply good bit wrong");
  a_refon: assert property (p_refon) else $error("reference on outside mode");
  a_rxen: assert property (p_rxen) else $error("wake enable mismatch");
  cover property (sfr_rd_in && sfr_addr_in == PSF_ADDR_FLAGS);
  cover property ($rose(rail_to_battery_out));
  cover property (rx_wake_enable_out && reference_keep_on_out);
endmodule : psf_supervisor_asserts
bind psf_supervisor psf_supervisor_asserts psf_supervisor_asserts_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
  .sfr_addr_in(sfr_addr_in), .sfr_rd_in(sfr_rd_in), .ext_irq0_pin_in(ext_irq0_pin_in), .main_low_in(main_low_in),
  .dc_input_low_in(dc_input_low_in), .main_good_in(main_good_in), .sag_in(sag_in), .lock_lost_in(lock_lost_in),
  .deepest_battery_mode_in(deepest_battery_mode_in), .sfr_rdata_out(sfr_rdata_out),
  .rail_to_battery_out(rail_to_battery_out), .reference_keep_on_out(reference_keep_on_out),
  .external_irq_zero_out(external_irq_zero_out), .rx_pin_function_out(rx_pin_function_out),
  .rx_wake_enable_out(rx_wake_enable_out));

// >>> bench/psf_supply_model.sv
/* Main supply monitor model.
   Assumes fail_in is a level from the bench. */
`timescale 1ns/1ps
module psf_supply_model
(
  input  wire logic sys_clk_in,
  input  wire logic fail_in,
  output logic      main_low_out,
  output logic      main_good_out
);
  initial main_low_out = 1'b0;
  initial main_good_out = 1'b1;
  always @(negedge sys_clk_in)
  begin
    main_low_out <= fail_in;
    main_good_out <= !fail_in;
  end
endmodule : psf_supply_model

// >>> rtl/psf_edge.sv
/*
  Rising and falling edge detector for one synchronous level.
  Assumes the level is already synchronous to sys_clk_in.
*/
`timescale 1ns/1ps
module psf_edge
  import psf_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  input  wire logic level_in,
  input  wire logic reset_level_in,
  output logic      rise_out,
  output logic      fall_out
);
  logic prev_q;
  logic seen_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      prev_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      prev_q <= level_in;
      seen_q <= 1'b1;
    end
  end

  // First cycle after reset compares against the reset level
  assign rise_out = level_in & ~(seen_q ? prev_q : reset_level_in);
  assign fall_out = ~level_in & (seen_q ? prev_q : reset_level_in);
endmodule : psf_edge

// >>> rtl/psf_flag.sv
/*
  One sticky event flag with software clear.
  Assumes clear comes from a register write of zero.
*/
`timescale 1ns/1ps
module psf_flag
  import psf_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clr_in)
      flag_out <= 1'b0;
  end
endmodule : psf_flag

// >>> rtl/psf_pkg.sv
/*
  Constants of the power supervisor flag and switchover block.
  Assumes an 8-bit special-function register port driven by the core.
*/
package psf_pkg;
  localparam logic [7:0] PSF_ADDR_PERIPHERAL_CONFIG   = 8'hf4;
  localparam logic [7:0] PSF_ADDR_SWCFG    = 8'hf5;
  localparam logic [7:0] PSF_ADDR_FLAGS    = 8'hf8;
  localparam logic [7:0] PSF_ADDR_IRQEN    = 8'hec;
  localparam logic [7:0] PSF_ADDR_WAKECFG  = 8'hff;
  localparam logic [7:0] PSF_ADDR_CONVST   = 8'hd8;
  localparam logic [7:0] PSF_BITADDR_BASE  = 8'hf8;
  localparam logic [4:0] PSF_BITADDR_HI    = 5'h1f;
  localparam int         PSF_ACK_BIT       = 0;
  localparam int         PSF_F_RESTORED    = 7;
  localparam int         PSF_F_SUMMARY     = 6;
  localparam int         PSF_F_DIP         = 5;
  localparam int         PSF_F_DCCONV      = 3;
  localparam int         PSF_F_BATLOW      = 2;
  localparam int         PSF_F_TOBAT       = 1;
  localparam int         PSF_F_DCLOW       = 0;
  localparam int         PSF_P_RXWAKE      = 7;
  localparam int         PSF_P_SOURCE      = 6;
  localparam int         PSF_P_GOOD        = 5;
  localparam int         PSF_P_LOCK        = 4;
  localparam int         PSF_P_REFON       = 3;
  localparam logic [7:0] PSF_FLAGS_RST     = 8'h00;
  localparam logic [7:0] PSF_SWCFG_RST     = 8'h00;
  localparam logic [7:0] PSF_IRQEN_RST     = 8'h00;
  localparam logic [1:0] PSF_RXFN_RST      = 2'h0;
  localparam logic [1:0] PSF_RX_GPIO       = 2'h0;
  localparam logic [1:0] PSF_RX_NOWAKE     = 2'h1;
  localparam logic [1:0] PSF_RX_WAKE       = 2'h3;
  typedef enum logic [1:0] {
    PSF_RAIL_MAIN = 2'b00,
    PSF_RAIL_BAT  = 2'b01
  } psf_rail_type;
endpackage : psf_pkg

// >>> rtl/psf_supervisor.sv
/*
  Power supervisor: event flags, battery switchover select, supply status
  and wake-up pin configuration, reached through the core register port.
  Assumes monitor inputs are synchronous levels or one-cycle pulses.
*/
`timescale 1ns/1ps
module psf_supervisor
  import psf_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic       bit_wr_in,
  input  wire logic [7:0] bit_addr_in,
  input  wire logic       bit_val_in,
  input  wire logic       main_low_in,
  input  wire logic       main_good_in,
  input  wire logic       dc_input_low_in,
  input  wire logic       dc_delta_in,
  input  wire logic       dc_ready_in,
  input  wire logic       battery_below_in,
  input  wire logic       battery_ready_in,
  input  wire logic       sag_in,
  input  wire logic       lock_lost_in,
  input  wire logic       deepest_battery_mode_in,
  input  wire logic       rx_edge_in,
  input  wire logic       ext_irq0_pin_in,
  output logic [7:0]      sfr_rdata_out,
  output logic            rail_to_battery_out,
  output logic            reference_keep_on_out,
  output logic            external_irq_zero_out,
  output logic [1:0]      rx_pin_function_out,
  output logic            rx_wake_enable_out,
  output logic            wake_request_out,
  output logic            power_irq_out
);
  logic [7:0]   irq_en_q;
  logic [1:0]   switchover_select_q;
  logic         ext_irq0_select_q;
  logic         reference_keep_on_q;
  logic         rail_src_main_q;
  logic         main_good_q;
  logic         rx_wake_source_q;
  logic         lock_loss_fault_q;
  logic [7:0]   flags;
  logic [7:0]   flag_set;
  logic [7:0]   flag_clr;
  logic         to_bat_d;
  logic         bat_rise;
  logic         bat_fall;
  psf_rail_type rail_q;
  logic         wr_flags;
  logic         wr_peripheral_config;
  logic         ack_wr;

  assign wr_flags  = sfr_wr_in && sfr_addr_in == PSF_ADDR_FLAGS;
  assign wr_peripheral_config = sfr_wr_in && sfr_addr_in == PSF_ADDR_PERIPHERAL_CONFIG;
  assign ack_wr    = (sfr_wr_in && sfr_addr_in == PSF_ADDR_CONVST && sfr_wdata_in[PSF_ACK_BIT])
                   || (bit_wr_in && bit_addr_in == PSF_ADDR_CONVST && bit_val_in);

  // Switchover decision from the select field
  always_comb
  begin
    case (switchover_select_q)
      2'b00:   to_bat_d = main_low_in;
      2'b01:   to_bat_d = main_low_in | dc_input_low_in;
      default: to_bat_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rail_q <= PSF_RAIL_MAIN;
    else
    begin
      case (rail_q)
        PSF_RAIL_MAIN: if (to_bat_d) rail_q <= PSF_RAIL_BAT;
        PSF_RAIL_BAT:  if (!to_bat_d) rail_q <= PSF_RAIL_MAIN;
        default:       rail_q <= PSF_RAIL_MAIN;
      endcase
    end
  end

  psf_edge u_rail_edge (
    .sys_clk_in     (sys_clk_in),
    .arst_n_in      (arst_n_in),
    .level_in       (rail_q == PSF_RAIL_BAT),
    .reset_level_in (1'b0),
    .rise_out       (bat_rise),
    .fall_out       (bat_fall)
  );

  // Event sources per flag bit
  always_comb
  begin
    flag_set                 = 8'h00;
    flag_set[PSF_F_RESTORED] = bat_fall;
    flag_set[PSF_F_DIP]      = sag_in;
    flag_set[PSF_F_DCCONV]   = dc_delta_in | dc_ready_in;
    flag_set[PSF_F_BATLOW]   = battery_below_in | battery_ready_in;
    flag_set[PSF_F_TOBAT]    = bat_rise;
    flag_set[PSF_F_DCLOW]    = dc_input_low_in;
    flag_set[PSF_F_SUMMARY]  = |(flag_set & irq_en_q & 8'hbf);
  end

  // Byte write of 0 or bit write of 0 clears a flag
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      assign flag_clr[gi] = (wr_flags && !sfr_wdata_in[gi])
                          || (bit_wr_in && !bit_val_in
                              && bit_addr_in == (PSF_BITADDR_BASE | 8'(gi)));
      psf_flag u_flag (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .set_in     (flag_set[gi]),
        .clr_in     (flag_clr[gi]),
        .flag_out   (flags[gi])
      );
    end
  endgenerate

  // Writable configuration
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_en_q            <= PSF_IRQEN_RST;
      switchover_select_q <= PSF_SWCFG_RST[1:0];
      ext_irq0_select_q   <= 1'b0;
      reference_keep_on_q <= 1'b0;
      rx_pin_function_out <= PSF_RXFN_RST;
    end
    else if (sfr_wr_in)
    begin
      case (sfr_addr_in)
        PSF_ADDR_IRQEN:   irq_en_q <= sfr_wdata_in;
        PSF_ADDR_SWCFG:   switchover_select_q <= sfr_wdata_in[1:0];
        PSF_ADDR_WAKECFG: ext_irq0_select_q <= sfr_wdata_in[0];
        PSF_ADDR_PERIPHERAL_CONFIG:
        begin
          reference_keep_on_q <= sfr_wdata_in[PSF_P_REFON];
          rx_pin_function_out <= sfr_wdata_in[1:0];
        end
        default: ;
      endcase
    end
  end

  // Status: source, health, wake and lock fault
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rail_src_main_q   <= 1'b1;
      main_good_q       <= 1'b1;
      rx_wake_source_q  <= 1'b0;
      lock_loss_fault_q <= 1'b0;
    end
    else
    begin
      rail_src_main_q <= (rail_q == PSF_RAIL_MAIN);
      main_good_q     <= main_good_in;
      if (rx_edge_in && deepest_battery_mode_in && rx_pin_function_out == PSF_RX_WAKE)
        rx_wake_source_q <= 1'b1;
      else if (wr_peripheral_config && !sfr_wdata_in[PSF_P_RXWAKE])
        rx_wake_source_q <= 1'b0;
      if (lock_lost_in)
        lock_loss_fault_q <= 1'b1;
      else if (ack_wr)
        lock_loss_fault_q <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rail_to_battery_out   <= 1'b0;
      reference_keep_on_out <= 1'b0;
      external_irq_zero_out <= 1'b0;
      rx_wake_enable_out    <= 1'b0;
      wake_request_out      <= 1'b0;
      power_irq_out         <= 1'b0;
    end
    else
    begin
      rail_to_battery_out   <= to_bat_d;
      reference_keep_on_out <= reference_keep_on_q & deepest_battery_mode_in;
      external_irq_zero_out <= ext_irq0_pin_in & ext_irq0_select_q;
      rx_wake_enable_out    <= (rx_pin_function_out == PSF_RX_WAKE);
      wake_request_out      <= rx_edge_in && deepest_battery_mode_in
                               && rx_pin_function_out == PSF_RX_WAKE;
      power_irq_out         <= flags[PSF_F_SUMMARY];
    end
  end

  // Read port
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sfr_rdata_out <= 8'h00;
    else if (sfr_rd_in)
    begin
      case (sfr_addr_in)
        PSF_ADDR_FLAGS:   sfr_rdata_out <= flags;
        PSF_ADDR_IRQEN:   sfr_rdata_out <= irq_en_q;
        PSF_ADDR_SWCFG:   sfr_rdata_out <= {6'h00, switchover_select_q};
        PSF_ADDR_WAKECFG: sfr_rdata_out <= {7'h00, ext_irq0_select_q};
        PSF_ADDR_PERIPHERAL_CONFIG:  sfr_rdata_out <= {rx_wake_source_q, rail_src_main_q, main_good_q,
                                            lock_loss_fault_q, reference_keep_on_q, 1'b0,
                                            rx_pin_function_out};
        default:          sfr_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule : psf_supervisor
